// ===== hw/ifa_pkg.sv
package ifa_pkg;
    // Bus clock and spike filtering
    localparam int CLK_NS = 50;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC_RAW = SPIKE_NS / CLK_NS;
    localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    localparam logic [2:0] ADDR_PREFIX = 3'h6;
    // Three-state select pin codes
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_FLOAT = 2'h2;
    // Status byte field positions, channel n at bit n*4
    localparam int ST_OVP = 0;
    localparam int ST_OPEN = 1;
    localparam int ST_SHORT = 2;
    localparam int ST_OVERCUR = 3;
    localparam logic [9:0] STATUS_RESET = 10'h000;
    localparam int NUM_CH = 2;
    // One channel's comparator causes
    typedef struct packed {
        logic feedback_overvoltage_fault;
        logic open_string_fault;
        logic shorted_string_fault;
        logic overcurrent_fault;
    } ifa_ch_fault_t;
    // Sensed level of a select pin from its two input comparators
    typedef struct packed {
        logic above_high;
        logic below_low;
    } ifa_sel_pin_t;
    typedef enum {IFA_IDLE, IFA_ADDR, IFA_ADDR_ACK, IFA_WR_DATA, IFA_WR_ACK,
                  IFA_RD_DATA, IFA_RD_ACK} ifa_state_t;
endpackage

// ===== hw/ifa_target.sv
`timescale 1ns/10ps
// Overview of operation
// - Answer to 7-bit address 110 followed by a four-bit suffix, then R/W.
// - Each select pin is sensed as low, high or floating.
// - Data line is only pulled low, during reads and acks; otherwise released.
// - Clock and data pulses of 50 ns or less are ignored.
// - Alert pulls low on any of ten fault causes.
// - Alert stays low until causes are gone and latched bits cleared.
// - Dim input low stops switching, enters standby, drives disconnect gate high.
// - Sense target is (code+1)/256 of full scale, zero when analog level low.
// - Feedback overvoltage stops switches, latches status, alerts, gate high.
// - Shorted string stops switches, latches status, alerts, isolates string.
module ifa_target (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Two-wire bus pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Address select pins
    input wire ifa_pkg::ifa_sel_pin_t ADDR_SELECT_A,
    input wire ifa_pkg::ifa_sel_pin_t ADDR_SELECT_B,
    // Fault causes and fault clear
    input wire ifa_pkg::ifa_ch_fault_t [1:0] CH_FAULT,
    input wire logic SUPPLY_UNDERVOLTAGE,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic FAULT_CLEAR,
    // Alert pin
    output logic ALERT_OUT,
    output logic ALERT_OE,
    // Channel control
    input wire logic [1:0] DIM_IN,
    input wire logic [1:0] LEVEL_BELOW_MIN,
    input wire logic [1:0][7:0] ANALOG_DIM_CODE,
    output logic [1:0] SWITCH_EN,
    output logic [1:0] STANDBY,
    output logic [1:0] LOAD_DISCONNECT_GATE,
    output logic [1:0][8:0] SENSE_TARGET
);
    import ifa_pkg::*;

    // Pin inputs except RST, FAULT_CLEAR and ANALOG_DIM_CODE pass two flip-flops first
    localparam int NSYNC = 2 + 4 + 8 + 2 + 2 + 2;
    logic [NSYNC-1:0] sync1, sync2;
    always_ff @(posedge CLK) begin
        sync1 <= {SCL_IN, SDA_IN, ADDR_SELECT_A, ADDR_SELECT_B, CH_FAULT,
                  SUPPLY_UNDERVOLTAGE, THERMAL_SHUTDOWN, DIM_IN, LEVEL_BELOW_MIN};
        sync2 <= sync1;
    end
    wire logic [1:0] bus_s = sync2[19:18];
    wire ifa_sel_pin_t sel_a_s = sync2[17:16];
    wire ifa_sel_pin_t sel_b_s = sync2[15:14];
    wire ifa_ch_fault_t [1:0] fault_s = sync2[13:6];
    wire logic uv_s = sync2[5];
    wire logic ot_s = sync2[4];
    wire logic [1:0] dim_s = sync2[3:2];
    wire logic [1:0] lvl_low_s = sync2[1:0];

    // Spike filters, one per bus line; a change must persist SPIKE_CYC+1 cycles
    logic [1:0] bus_f;
    logic [1:0][1:0] flt_cnt;
    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge CLK) begin
            if (RST) begin
                bus_f[i] <= 1'b1;
                flt_cnt[i] <= 2'h0;
            end else if (bus_s[i] == bus_f[i]) begin
                flt_cnt[i] <= 2'h0;
            end else if (flt_cnt[i] == 2'(SPIKE_CYC)) begin
                bus_f[i] <= bus_s[i];
                flt_cnt[i] <= 2'h0;
            end else begin
                flt_cnt[i] <= flt_cnt[i] + 2'h1;
            end
        end
    end
    logic [1:0] bus_d;
    always_ff @(posedge CLK) begin
        bus_d <= RST ? 2'h3 : bus_f;
    end
    wire logic scl_f = bus_f[1];
    wire logic sda_f = bus_f[0];
    wire logic scl_rise = scl_f & ~bus_d[1];
    wire logic scl_fall = ~scl_f & bus_d[1];
    wire logic start_cond = scl_f & bus_d[1] & bus_d[0] & ~sda_f;
    wire logic stop_cond = scl_f & bus_d[1] & ~bus_d[0] & sda_f;

    // Three-state sensing; neither comparator tripped means floating
    function automatic logic [1:0] sel_state(input ifa_sel_pin_t p);
        if (p.above_high) return SEL_HIGH;
        if (p.below_low) return SEL_LOW;
        return SEL_FLOAT;
    endfunction
    // Fixed suffix table indexed by 3*a+b
    function automatic logic [3:0] suffix_of(input logic [1:0] a, input logic [1:0] b);
        logic [3:0] idx;
        idx = 4'(a) * 4'h3 + 4'(b);
        case (idx)
            4'h0: return 4'h0;
            4'h1: return 4'h1;
            4'h2: return 4'h2;
            4'h3: return 4'h3;
            4'h4: return 4'h4;
            4'h5: return 4'h5;
            4'h6: return 4'h6;
            4'h7: return 4'h7;
            default: return 4'h8;
        endcase
    endfunction

    // Address caught once after reset release, pins are static straps
    logic [3:0] own_suffix;
    logic [1:0] capt_wait;
    always_ff @(posedge CLK) begin
        if (RST) begin
            capt_wait <= 2'h0;
            own_suffix <= 4'h0;
        end else if (capt_wait != 2'h3) begin
            capt_wait <= capt_wait + 2'h1;
            own_suffix <= suffix_of(sel_state(sel_a_s), sel_state(sel_b_s));
        end
    end

    // Fault causes and latched indications
    logic [9:0] causes;
    logic [9:0] status;
    always_comb begin
        causes = {uv_s, ot_s, 8'h00};
        for (int c = 0; c < NUM_CH; c++) begin
            causes[c*4+ST_OVP] = fault_s[c].feedback_overvoltage_fault;
            causes[c*4+ST_OPEN] = fault_s[c].open_string_fault;
            causes[c*4+ST_SHORT] = fault_s[c].shorted_string_fault;
            causes[c*4+ST_OVERCUR] = fault_s[c].overcurrent_fault;
        end
    end
    // Set beats clear so a cause arriving during a clear is kept
    always_ff @(posedge CLK) begin
        if (RST) begin
            status <= STATUS_RESET;
        end else begin
            status <= (FAULT_CLEAR ? 10'h000 : status) | causes;
        end
    end
    wire logic alert_now = (|causes) | (|status);
    always_ff @(posedge CLK) begin
        ALERT_OUT <= 1'b0;
        ALERT_OE <= RST ? 1'b0 : alert_now;
    end

    // Per-channel power control
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        wire logic trip = fault_s[c].feedback_overvoltage_fault
                          | fault_s[c].shorted_string_fault;
        always_ff @(posedge CLK) begin
            if (RST) begin
                SWITCH_EN[c] <= 1'b0;
                STANDBY[c] <= 1'b1;
                LOAD_DISCONNECT_GATE[c] <= 1'b1;
                SENSE_TARGET[c] <= 9'h000;
            end else begin
                SWITCH_EN[c] <= dim_s[c] & ~trip;
                STANDBY[c] <= ~dim_s[c];
                LOAD_DISCONNECT_GATE[c] <= ~dim_s[c] | trip;
                SENSE_TARGET[c] <= lvl_low_s[c] ? 9'h000
                                   : {1'b0, ANALOG_DIM_CODE[c]} + 9'h001;
            end
        end
    end

    // Bus target state machine; data changes only while the clock is low
    ifa_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw_read, master_nack;
    wire logic addr_match = shreg[7:1] == {ADDR_PREFIX, own_suffix};
    always_ff @(posedge CLK) begin
        SDA_OUT <= 1'b0;
        if (RST) begin
            state <= IFA_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw_read <= 1'b0;
            master_nack <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (stop_cond) begin
            state <= IFA_IDLE;
            SDA_OE <= 1'b0;
        end else if (start_cond) begin
            state <= IFA_ADDR;
            bit_cnt <= 4'h0;
            SDA_OE <= 1'b0;
        end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state == IFA_ADDR || state == IFA_WR_DATA) begin
                shreg <= {shreg[6:0], sda_f};
            end
            if (state == IFA_RD_ACK) begin
                master_nack <= sda_f;
            end
        end else if (scl_fall) begin
            case (state)
                IFA_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        state <= addr_match ? IFA_ADDR_ACK : IFA_IDLE;
                        SDA_OE <= addr_match;
                        rw_read <= shreg[0];
                    end
                end
                IFA_ADDR_ACK, IFA_WR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (state == IFA_ADDR_ACK && rw_read) begin
                        state <= IFA_RD_DATA;
                        shreg <= status[7:0];
                        SDA_OE <= ~status[7];
                    end else begin
                        state <= IFA_WR_DATA;
                        SDA_OE <= 1'b0;
                    end
                end
                IFA_WR_DATA: begin
                    if (bit_cnt == 4'h8) begin
                        state <= IFA_WR_ACK;
                        SDA_OE <= 1'b1;
                    end
                end
                IFA_RD_DATA: begin
                    if (bit_cnt == 4'h8) begin
                        state <= IFA_RD_ACK;
                        SDA_OE <= 1'b0;
                    end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        SDA_OE <= ~shreg[6];
                    end
                end
                IFA_RD_ACK: begin
                    bit_cnt <= 4'h0;
                    if (master_nack) begin
                        state <= IFA_IDLE;
                    end else begin
                        state <= IFA_RD_DATA;
                        shreg <= status[7:0];
                        SDA_OE <= ~status[7];
                    end
                end
                default: begin
                    SDA_OE <= 1'b0;
                end
            endcase
        end
    end

    // Checks
    sequence s_glitch(idx);
        (bus_s[idx] != bus_f[idx]) && (flt_cnt[idx] == 2'h0) ##1 (bus_s[idx] == bus_f[idx]);
    endsequence
    // Both lines are watched; the bench spikes each of them once per write
    for (genvar i = 0; i < 2; i++) begin : g_spike
        a_spike_ignored: assert property (@(posedge CLK) disable iff (RST)
            s_glitch(i) |=> $stable(bus_f[i])) else $error("bus spike passed filter");
    end
    a_sda_low_only: assert property (@(posedge CLK) disable iff (RST)
        SDA_OE |-> (SDA_OUT == 1'b0) && state inside {IFA_ADDR_ACK, IFA_WR_ACK,
        IFA_RD_DATA}) else $error("data line driven outside ack or read");
    a_addr_ack_match: assert property (@(posedge CLK) disable iff (RST)
        (state == IFA_ADDR) && scl_fall && (bit_cnt == 4'h8) && !stop_cond && !start_cond
        |=> (state == IFA_ADDR_ACK) == (shreg[7:5] == 3'h6 && shreg[4:1] == own_suffix))
        else $error("address acknowledge mismatch");
    a_alert_on_cause: assert property (@(posedge CLK) disable iff (RST)
        (|causes) |=> ALERT_OE ##1 ALERT_OE) else $error("alert missed a cause");
    a_alert_release: assert property (@(posedge CLK) disable iff (RST)
        $fell(ALERT_OE) |-> $past(causes) == 10'h000 && $past(status) == 10'h000)
        else $error("alert released while a fault remains");
    a_latch_hold: assert property (@(posedge CLK) disable iff (RST)
        (status != 10'h000) && !FAULT_CLEAR |=> (status & $past(status)) == $past(status))
        else $error("latched fault lost without clear");
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
        a_dim_standby: assert property (@(posedge CLK) disable iff (RST)
            !dim_s[c] |=> STANDBY[c] && !SWITCH_EN[c] && LOAD_DISCONNECT_GATE[c])
            else $error("dim low did not stop channel");
        a_ovp_trip: assert property (@(posedge CLK) disable iff (RST)
            fault_s[c].feedback_overvoltage_fault |=> !SWITCH_EN[c]
            && LOAD_DISCONNECT_GATE[c] && status[c*4+ST_OVP] && ALERT_OE)
            else $error("overvoltage not handled");
        a_short_trip: assert property (@(posedge CLK) disable iff (RST)
            fault_s[c].shorted_string_fault |=> !SWITCH_EN[c]
            && LOAD_DISCONNECT_GATE[c] && status[c*4+ST_SHORT] && ALERT_OE)
            else $error("shorted string not handled");
        a_target_scale: assert property (@(posedge CLK) disable iff (RST)
            1'b1 |=> SENSE_TARGET[c] == ($past(lvl_low_s[c]) ? 9'h000
            : 9'($past(ANALOG_DIM_CODE[c])) + 9'h001))
            else $error("sense target wrong");
    end
    a_addr_capture: assert property (@(posedge CLK) disable iff (RST)
        (capt_wait == 2'h3) |=> $stable(own_suffix)) else $error("address changed after capture");
endmodule // ifa_target

// ===== test/ifa_host.sv
`timescale 1ns/10ps
// Bus controller model; lines move on the falling clock edge
module ifa_host (
    // Clock
    input wire logic CLK,
    // Bus lines, SDA_DRV low pulls the data line down
    output logic SCL,
    output logic SDA_DRV,
    input wire logic SDA
);
    localparam int HALF = 26; // 1.3 us phases keep the bit rate under 400 kHz
    initial begin
        SCL = 1'b1;
        SDA_DRV = 1'b1;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // Start or repeated start; data settles well clear of the clock fall
    task automatic start();
        pause(4);
        SDA_DRV = 1'b1;
        pause(HALF);
        SCL = 1'b1;
        pause(HALF);
        SDA_DRV = 1'b0;
        pause(HALF);
        SCL = 1'b0;
    endtask
    task automatic stop();
        pause(4);
        SDA_DRV = 1'b0;
        pause(HALF);
        SCL = 1'b1;
        pause(HALF);
        SDA_DRV = 1'b1;
        pause(HALF);
    endtask
    // One bit; a glitch spikes the clock high for one cycle in the low phase
    // and drops data for one cycle while the clock is high
    task automatic bit_io(input logic b, input logic glitch, output logic r);
        pause(4);
        SDA_DRV = b;
        pause(HALF / 2);
        SCL = glitch;
        pause(1);
        SCL = 1'b0;
        pause(HALF / 2);
        SCL = 1'b1;
        pause(HALF / 2);
        r = SDA;
        if (glitch) begin
            SDA_DRV = 1'b0;
            pause(1);
            SDA_DRV = b;
        end
        pause(HALF / 2);
        SCL = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic glitch, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], glitch && i == 3, r[i]);
        end
    endtask
endmodule // ifa_host

// ===== test/i2c_target_address_and_fault_alert_bench.sv
`timescale 1ns/10ps
module i2c_target_address_and_fault_alert_bench;
    import ifa_pkg::*;
    logic clk, rst, scl, sda_drv, sda_out, sda_oe, alert_out, alert_oe, uv, ot, clr, trip, aexp;
    wire sda;
    ifa_sel_pin_t sel_a, sel_b;
    ifa_ch_fault_t [1:0] ch_fault;
    logic [1:0] dim, below, sw_en, stby, gate;
    logic [1:0][7:0] code;
    logic [1:0][8:0] target;
    logic [31:0] seed, r;
    int n_errors = 0;
    int tests_run = 0;
    // Released data line is pulled up by the bus resistor
    assign sda = sda_drv & !(sda_oe && !sda_out);
    ifa_host i_host (.CLK(clk), .SCL(scl), .SDA_DRV(sda_drv), .SDA(sda));
    ifa_target i_dut (
        .CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .ADDR_SELECT_A(sel_a), .ADDR_SELECT_B(sel_b), .CH_FAULT(ch_fault),
        .SUPPLY_UNDERVOLTAGE(uv), .THERMAL_SHUTDOWN(ot), .FAULT_CLEAR(clr),
        .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .DIM_IN(dim), .LEVEL_BELOW_MIN(below),
        .ANALOG_DIM_CODE(code), .SWITCH_EN(sw_en), .STANDBY(stby),
        .LOAD_DISCONNECT_GATE(gate), .SENSE_TARGET(target)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Pin state 0 low, 1 high, 2 floating; above_high is the upper bit
    function automatic ifa_sel_pin_t enc(input int v);
        return ifa_sel_pin_t'((v == 0) ? 2'b01 : (v == 1) ? 2'b10 : 2'b00);
    endfunction
    function automatic logic [7:0] exp_status(input ifa_ch_fault_t [1:0] f);
        logic [7:0] s;
        for (int c = 0; c < 2; c++) begin
            s[c*4 +: 4] = {f[c].overcurrent_fault, f[c].shorted_string_fault,
                           f[c].open_string_fault, f[c].feedback_overvoltage_fault};
        end
        return s;
    endfunction
    task automatic check_flag(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic check_word(input string name, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic clear_faults();
        repeat (3) @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Two status bytes on a hit, master acks the first and refuses the second
    task automatic bus_read(input logic [6:0] a, input logic hit, input logic [7:0] e);
        logic [7:0] d;
        logic ack;
        i_host.start();
        i_host.byte_io({a, 1'b1}, 1'b0, d);
        i_host.bit_io(1'b1, 1'b0, ack);
        check_flag("addr ack", !hit, ack);
        for (int n = 0; n < 2 && hit; n++) begin
            i_host.byte_io(8'hff, 1'b0, d);
            check_word("read byte", {1'b0, e}, {1'b0, d});
            i_host.bit_io(n == 1, 1'b0, ack);
        end
        i_host.stop();
    endtask
    // Write byte carries a data glitch that must not look like a start
    task automatic bus_write(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] d;
        logic ack;
        i_host.start();
        i_host.byte_io({a, 1'b0}, 1'b0, d);
        i_host.bit_io(1'b1, 1'b0, ack);
        i_host.byte_io(v | 8'h08, 1'b1, d);
        i_host.bit_io(1'b1, 1'b0, ack);
        check_flag("write ack", 1'b0, ack);
        i_host.stop();
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Four bus passes per strap pair plus the channel loop need about 39k cycles
    initial begin
        repeat (95000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        {rst, uv, ot, clr, dim, below, code, ch_fault} = '0;
        sel_a = enc(0);
        sel_b = enc(0);
        seed = 32'd28986;
        for (int k = 0; k < 9; k++) begin
            sel_a = enc(k / 3);
            sel_b = enc(k % 3);
            rst = 1'b1;
            repeat (12) @(negedge clk);
            rst = 1'b0;
            repeat (10) @(negedge clk);
            r = rnd();
            ch_fault = r[7:0];
            uv = (k == 3);
            ot = (k == 5);
            aexp = (r[7:0] != 8'h00) || k == 3 || k == 5;
            repeat (4) @(negedge clk);
            check_flag("alert", aexp, alert_oe);
            bus_read({ADDR_PREFIX, 4'(k)}, 1'b1, exp_status(ch_fault));
            bus_read({ADDR_PREFIX, 4'((k + 4) % 9)}, 1'b0, 8'h00);
            bus_read({3'h2, 4'(k)}, 1'b0, 8'h00);
            bus_write({ADDR_PREFIX, 4'(k)}, r[15:8]);
            {ch_fault, uv, ot} = '0;
            repeat (4) @(negedge clk);
            check_flag("alert held", aexp, alert_oe);
            clear_faults();
            check_flag("alert cleared", 1'b0, alert_oe);
        end
        // Random channel settings, trips on either channel, extreme codes first
        for (int t = 0; t < 24; t++) begin
            r = rnd();
            dim = r[1:0];
            below = r[3:2] & {2{r[4]}};
            code = (t == 0) ? {8'hff, 8'h00} : r[31:16];
            ch_fault[0].feedback_overvoltage_fault = r[5] & r[6];
            ch_fault[1].shorted_string_fault = r[7] & r[8];
            repeat (4) @(negedge clk);
            for (int c = 0; c < 2; c++) begin
                trip = (c == 0) ? (r[5] & r[6]) : (r[7] & r[8]);
                check_flag("switch", dim[c] & !trip, sw_en[c]);
                check_flag("gate", !dim[c] | trip, gate[c]);
                if (!trip) check_flag("standby", !dim[c], stby[c]);
                check_word("target", below[c] ? 9'h000 : {1'b0, code[c]} + 9'h001, target[c]);
            end
            check_flag("trip alert", (r[5] & r[6]) | (r[7] & r[8]), alert_oe);
            check_flag("alert level", 1'b0, alert_out);
            check_flag("data level", 1'b0, sda_out);
            // A clear while the trip cause still stands must not drop the alert
            clear_faults();
            check_flag("clear vs cause", (r[5] & r[6]) | (r[7] & r[8]), alert_oe);
            ch_fault = '0;
            clear_faults();
        end
        print_verdict();
    end
endmodule // i2c_target_address_and_fault_alert_bench
